// >>> rtl/ext_irq_pkg.sv
package ext_irq_pkg;

	// Clock rates; the fast clock is the module clock itself
	localparam int CLK_HZ  = 10_000_000;
	localparam int FC_HZ   = 10_000_000;
	localparam int FS_HZ   = 32_768;
	localparam int FC_CYC  = CLK_HZ / FC_HZ;
	// Slow clock enable divider, rounded down to whole cycles
	localparam int FS_DIV  = CLK_HZ / FS_HZ;
	localparam logic [8:0] FS_DIV_LAST = 9'(FS_DIV - 1);

	// Noise times in fast clock periods, as figures
	localparam int REJECT_ZERO_FC      = 2;
	localparam int ACCEPT_ZERO_FC      = 7;
	localparam int REJECT_ONE_LONG_FC  = 63;
	localparam int REJECT_ONE_SHORT_FC = 15;
	localparam int ACCEPT_ONE_SHORT_FC = 49;
	localparam int ACCEPT_ONE_LONG_FC  = 193;
	localparam int REJECT_THREE_FC     = 7;
	localparam int ACCEPT_THREE_FC     = 25;
	// Slow modes: reject below one slow period
	localparam int REJECT_SLOW_FS      = 1;
	localparam int NOISE_SWITCH_FC     = 64;

	// Filter thresholds in consecutive samples
	localparam logic [6:0] THR_ZERO      = 7'(REJECT_ZERO_FC * FC_CYC);
	localparam logic [6:0] THR_ONE_LONG  = 7'(REJECT_ONE_LONG_FC * FC_CYC);
	localparam logic [6:0] THR_ONE_SHORT = 7'(REJECT_ONE_SHORT_FC * FC_CYC);
	localparam logic [6:0] THR_THREE     = 7'(REJECT_THREE_FC * FC_CYC);
	// Two slow samples cannot both fall inside one slow period
	localparam logic [6:0] THR_SLOW      = 7'(REJECT_SLOW_FS + 1);

	// Register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX   = 8'h37;
	localparam logic [7:0] LATCH_IDX  = 8'h40;
	localparam logic [7:0] ENABLE_IDX = 8'h41;
	localparam logic [7:0] MISC_IDX   = 8'h42;
	localparam int ADDR_W = 12;

	// Control register fields
	localparam int CTRL_NOISE_BIT = 7;
	localparam int CTRL_PINFN_BIT = 6;
	localparam int SENSE3_LSB     = 4;
	localparam int SENSE4_LSB     = 2;
	localparam int EDGE1_BIT      = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hfe;

	// Misc register fields
	localparam int MISC_MASTER_BIT = 0;
	localparam int MISC_ROUTE_BIT  = 1;
	localparam int MISC_SLOW_BIT   = 2;
	localparam logic [2:0] MISC_RESET = 3'h0;

	// Sensitivity encodings
	localparam logic [1:0] SENSE_RISE  = 2'h0;
	localparam logic [1:0] SENSE_FALL  = 2'h1;
	localparam logic [1:0] SENSE_BOTH  = 2'h2;
	localparam logic [1:0] SENSE_LEVEL = 2'h3;

	// Source slots, lowest index wins priority
	localparam int NUM_SRC   = 5;
	localparam int SRC_ZERO  = 0;
	localparam int SRC_ONE   = 1;
	localparam int SRC_THREE = 2;
	localparam int SRC_FOUR  = 3;
	localparam int SRC_FIVE  = 4;

	// Startup: load filters, then arm edge detection
	localparam logic [2:0] START_LOAD = 3'h2;
	localparam logic [2:0] START_DONE = 3'h4;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/external_interrupt_inputs.sv
`timescale 1ns/10ps
`default_nettype none
module external_interrupt_inputs
	import ext_irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Interrupt pins
	input  wire logic              sharedPortPin,
	input  wire logic              extIrqOne,
	input  wire logic              extIrqThree,
	input  wire logic              extIrqFour,
	input  wire logic              extIrqFive,
	// Core side
	input  wire logic              timerFourIrq,
	input  wire logic              acceptStrobe,
	output var  logic              reqValid,
	output var  logic [2:0]        reqSource,
	output var  logic              portInValue
);
	// One-hot decode of a byte address: {misc, enable, latch, ctrl}
	function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] a);
		logic [3:0] hit;
		hit = 4'h0;
		if (a[1:0] == 2'h0) begin
			hit[0] = (a[ADDR_W-1:2] == 10'(CTRL_IDX));
			hit[1] = (a[ADDR_W-1:2] == 10'(LATCH_IDX));
			hit[2] = (a[ADDR_W-1:2] == 10'(ENABLE_IDX));
			hit[3] = (a[ADDR_W-1:2] == 10'(MISC_IDX));
		end
		return hit;
	endfunction
	// Sensitivity match for the selectable inputs
	function automatic logic senseHit(input logic [1:0] sel,
		input logic rise, input logic fall, input logic lvl,
		input logic armed);
		logic hit;
		hit = 1'b0;
		case (sel)
			SENSE_RISE:  hit = rise;
			SENSE_FALL:  hit = fall;
			SENSE_BOTH:  hit = rise | fall;
			SENSE_LEVEL: hit = lvl & armed;
			default:     hit = 1'b0;
		endcase
		return hit;
	endfunction
	logic              rstMeta_r;     // Reset release, first stage
	logic              rstSyncN;      // Reset release, used everywhere
	logic [NUM_SRC-1:0] pinMeta_r;    // Pin synchroniser, first stage
	logic [NUM_SRC-1:0] pinSync_r;    // Pin synchroniser, second stage
	logic [NUM_SRC-1:0] pinVec;       // Pins gathered by slot
	logic [NUM_SRC-1:0] filt;         // Filtered levels
	logic [NUM_SRC-1:0] filtPrev_r;   // Filtered levels, one cycle old
	logic [NUM_SRC-1:0] rise;         // Filtered rising edges
	logic [NUM_SRC-1:0] fall;         // Filtered falling edges
	logic [NUM_SRC-1:0] setEv;        // Latch set events
	logic [NUM_SRC-1:0] latch_r;      // Interrupt latches
	logic [NUM_SRC-1:0] enable_r;     // Per-source enables
	logic [NUM_SRC-1:0] pending;      // Latched and enabled
	logic [NUM_SRC-1:0] swClear;      // Software write-one clear
	logic [NUM_SRC-1:0] ackClear;     // Clear by acceptance
	logic [6:0]        thr [NUM_SRC]; // Filter threshold per slot
	logic [1:0]        armed_r;       // Level mode armed, three and four
	logic [7:0]        ctrl_r;        // External interrupt control
	logic [2:0]        misc_r;        // Master, route, slow mode
	logic [8:0]        fsCnt_r;       // Slow clock divider
	logic              fsTick_r;      // Slow clock enable pulse
	logic              sampleEn;      // Filter sample enable
	logic [2:0]        startCnt_r;    // Startup sequencer
	logic              started;       // Edge detection live
	logic              filtLoad;      // Filters take pin level
	logic              slowMode;      // Low-speed or sleep clocking
	logic              ev3;           // Input three event
	logic              ev4;           // Input four event
	logic              accepted;      // Core took the request
	logic              awHeld_r;      // Write address captured
	logic              wHeld_r;       // Write data captured
	logic [ADDR_W-1:0] awAddr_r;      // Captured write address
	logic [31:0]       wData_r;       // Captured write data
	logic              wLane0_r;      // Low byte lane enabled
	logic              doWrite;       // Both halves present
	logic [3:0]        wHit;          // Write decode
	logic [3:0]        rHit;          // Read decode
	logic [2:0]        firstSrc;      // Highest priority pending
	// Asynchronous assert, synchronous release of reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSyncN  <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSyncN  <= rstMeta_r;
		end
	end
	assign pinVec   = {extIrqFive, extIrqFour, extIrqThree, extIrqOne,
		sharedPortPin};
	assign slowMode = misc_r[MISC_SLOW_BIT];
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= pinVec;
			pinSync_r <= pinMeta_r;
		end
	end
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			portInValue <= 1'b0;
		end else begin
			portInValue <= pinSync_r[SRC_ZERO];
		end
	end
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			fsCnt_r  <= 9'h000;
			fsTick_r <= 1'b0;
		end else if (fsCnt_r == FS_DIV_LAST) begin
			fsCnt_r  <= 9'h000;
			fsTick_r <= 1'b1;
		end else begin
			fsCnt_r  <= fsCnt_r + 9'h001;
			fsTick_r <= 1'b0;
		end
	end
	// sample on fast or slow clock by mode
	assign sampleEn = slowMode ? fsTick_r : 1'b1;
	// Startup waits for synchronised pins, then primes filters
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			startCnt_r <= 3'h0;
		end else if (startCnt_r != START_DONE) begin
			startCnt_r <= startCnt_r + 3'h1;
		end
	end
	assign filtLoad = (startCnt_r == START_LOAD);
	assign started  = (startCnt_r == START_DONE);
	// Thresholds chosen live, so a noise select write acts at once
	// select acts immediately
	always_comb begin
		// short filter for zero and five
		thr[SRC_ZERO]  = THR_ZERO;
		thr[SRC_FIVE]  = THR_ZERO;
		// noise select picks long or short
		thr[SRC_ONE]   = ctrl_r[CTRL_NOISE_BIT] ? THR_ONE_SHORT
			: THR_ONE_LONG;
		// medium filter for three and four
		thr[SRC_THREE] = THR_THREE;
		thr[SRC_FOUR]  = THR_THREE;
		// slow modes use two slow samples
		if (slowMode) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				thr[i] = THR_SLOW;
			end
		end
	end
	generate
		for (genvar g = 0; g < NUM_SRC; g++) begin : gFilt
			noise_filter uFilt (
				.clk       (clk),
				.rstSyncN  (rstSyncN),
				.sampleEn  (sampleEn),
				.threshold (thr[g]),
				.load      (filtLoad),
				.din       (pinSync_r[g]),
				.dout      (filt[g])
			);
		end
	endgenerate
	// Edge detection history
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			filtPrev_r <= '0;
		end else begin
			filtPrev_r <= filt;
		end
	end
	assign rise = started ? (filt & ~filtPrev_r) : '0;
	assign fall = started ? (~filt & filtPrev_r) : '0;
	// level mode armed by a rising edge after reset
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			armed_r <= 2'h0;
		end else begin
			armed_r <= armed_r | {rise[SRC_FOUR], rise[SRC_THREE]};
		end
	end
	// two-bit sensitivity for three and four
	assign ev3 = senseHit(ctrl_r[SENSE3_LSB +: 2], rise[SRC_THREE],
		fall[SRC_THREE], filt[SRC_THREE], armed_r[0]);
	assign ev4 = senseHit(ctrl_r[SENSE4_LSB +: 2], rise[SRC_FOUR],
		fall[SRC_FOUR], filt[SRC_FOUR], armed_r[1]);
	// Latch set events per slot
	always_comb begin
		setEv[SRC_ZERO]  = fall[SRC_ZERO] & ctrl_r[CTRL_PINFN_BIT];
		setEv[SRC_ONE]   = ctrl_r[EDGE1_BIT] ? fall[SRC_ONE]
			: rise[SRC_ONE];
		// route picks input three or timer
		setEv[SRC_THREE] = misc_r[MISC_ROUTE_BIT] ? ev3 : timerFourIrq;
		setEv[SRC_FOUR]  = ev4;
		setEv[SRC_FIVE]  = fall[SRC_FIVE];
	end
	// Priority pick: lowest pending slot
	always_comb begin
		firstSrc = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				firstSrc = 3'(i);
			end
		end
	end
	assign pending  = latch_r & enable_r;
	assign accepted = acceptStrobe & reqValid;
	assign ackClear = accepted ? (NUM_SRC'(1) << reqSource) : '0;
	assign swClear  = (doWrite & wHit[1] & wLane0_r)
		? wData_r[NUM_SRC-1:0] : '0;
	// latch set the cycle after the filtered edge
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			latch_r <= '0;
		end else begin
			// A new event wins over a clear in the same cycle
			latch_r <= (latch_r & ~(swClear | ackClear)) | setEv;
		end
	end
	// request only with master flag set
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			reqValid  <= 1'b0;
			reqSource <= 3'h0;
		end else if (accepted) begin
			// Drop at once; the master flag is now being cleared
			reqValid  <= 1'b0;
		end else begin
			reqValid  <= misc_r[MISC_MASTER_BIT] & (|pending);
			reqSource <= firstSrc;
		end
	end
	// control register, bit 0 not stored
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ctrl_r <= CTRL_RESET;
		end else if (doWrite && wHit[0] && wLane0_r) begin
			ctrl_r <= wData_r[7:0] & CTRL_WMASK;
		end
	end
	// Enable register
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			enable_r <= '0;
		end else if (doWrite && wHit[2] && wLane0_r) begin
			enable_r <= wData_r[NUM_SRC-1:0];
		end
	end
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			misc_r <= MISC_RESET;
		end else if (doWrite && wHit[3] && wLane0_r) begin
			// Software write wins over a same-cycle acceptance
			misc_r <= wData_r[2:0];
		end else if (accepted) begin
			misc_r[MISC_MASTER_BIT] <= 1'b0;
		end
	end
	assign doWrite = awHeld_r & wHeld_r & ~bvalid;
	assign wHit    = decodeAddr(awAddr_r);
	assign rHit    = decodeAddr(araddr);
	// Write address channel, taken independently of data
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			awready  <= 1'b0;
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
		end else if (awvalid && awready) begin
			awready  <= 1'b0;
			awHeld_r <= 1'b1;
			awAddr_r <= awaddr;
		end else if (doWrite) begin
			awHeld_r <= 1'b0;
		end else if (!awHeld_r && !bvalid) begin
			awready  <= 1'b1;
		end
	end
	// Write data channel, taken independently of address
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			wready   <= 1'b0;
			wHeld_r  <= 1'b0;
			wData_r  <= '0;
			wLane0_r <= 1'b0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			wHeld_r  <= 1'b1;
			wData_r  <= wdata;
			wLane0_r <= wstrb[0];
		end else if (doWrite) begin
			wHeld_r  <= 1'b0;
		end else if (!wHeld_r && !bvalid) begin
			wready   <= 1'b1;
		end
	end
	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= (|wHit) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end
	// Read channel: one read in flight, data a cycle after address
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= (|rHit) ? RESP_OKAY : RESP_SLVERR;
			// Unused bits and unmapped addresses read zero
			rdata   <= rHit[0] ? {24'h0, ctrl_r}
				: rHit[1] ? {27'h0, latch_r}
				: rHit[2] ? {27'h0, enable_r}
				: rHit[3] ? {29'h0, misc_r} : 32'h0000_0000;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/noise_filter.sv
`timescale 1ns/10ps
`default_nettype none
module noise_filter
	import ext_irq_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstSyncN,
	input  wire logic       sampleEn,
	input  wire logic [6:0] threshold,
	input  wire logic       load,
	input  wire logic       din,
	output var  logic       dout
);

	logic [6:0] runCnt_r;   // Consecutive samples differing from dout

	// Output flips only after threshold differing samples in a row
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			dout     <= 1'b0;
			runCnt_r <= 7'h00;
		end else if (load) begin
			// Take the pin level so a held pin is no edge
			dout     <= din;
			runCnt_r <= 7'h00;
		end else if (sampleEn) begin
			if (din == dout) begin
				runCnt_r <= 7'h00;
			end else if (runCnt_r + 7'h01 >= threshold) begin
				dout     <= din;
				runCnt_r <= 7'h00;
			end else begin
				runCnt_r <= runCnt_r + 7'h01;
			end
		end
	end

endmodule
`default_nettype wire

// >>> test/ext_irq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ext_irq_monitor
	import ext_irq_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic              sharedPortPin,
	input wire logic              acceptStrobe,
	input wire logic              reqValid,
	input wire logic [2:0]        reqSource,
	input wire logic              portInValue
);
	// Cycles since reset release; the pin synchroniser needs time to fill
	logic [2:0] upCnt_r;
	// Decoded read address, word aligned and inside the map
	logic       mapped;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Saturating count, so the follow check never looks into reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_r <= 3'h0;
		end else if (upCnt_r != 3'h7) begin
			upCnt_r <= upCnt_r + 3'h1;
		end
	end

	assign mapped = araddr[1:0] == 2'h0 && araddr[11:10] == 2'h0
		&& araddr[9:2] inside {CTRL_IDX, LATCH_IDX, ENABLE_IDX, MISC_IDX};

	sequence sRdTake;
		arvalid && arready;
	endsequence
	sequence sWrTake;
		awvalid && awready && wvalid && wready;
	endsequence

	chk_port_follow: assert property (upCnt_r == 3'h7 |->
		portInValue == $past(sharedPortPin, 3)) else $error("port copy lags");
	chk_accept_drop: assert property (acceptStrobe && reqValid |=>
		!reqValid) else $error("request kept after acceptance");
	chk_src_range: assert property (reqValid |->
		reqSource <= 3'(NUM_SRC - 1)) else $error("source slot out of range");
	chk_wr_answer: assert property (sWrTake |=> ##[0:1] bvalid
		&& !awready) else $error("write answer missing");
	chk_b_stands: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp)) else $error("write answer dropped");
	chk_rd_answer: assert property (sRdTake |=> rvalid
		&& !arready) else $error("read answer missing");
	chk_r_stands: assert property (rvalid && !rready |=> rvalid
		&& $stable(rdata) && $stable(rresp)) else $error("read data moved");
	chk_rd_release: assert property (rvalid && rready |=>
		!rvalid ##1 (rvalid == $past(arvalid && arready)))
		else $error("read answer repeated");
	chk_unmapped_err: assert property (sRdTake and !mapped |=>
		rresp == RESP_SLVERR && rdata == 32'h0) else $error("bad unmapped read");
endmodule

bind external_interrupt_inputs ext_irq_monitor u_ext_irq_monitor (
	.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.sharedPortPin(sharedPortPin), .acceptStrobe(acceptStrobe),
	.reqValid(reqValid), .reqSource(reqSource), .portInValue(portInValue));
`default_nettype wire

// >>> test/ext_pin_source.sv
`timescale 1ns/10ps
`default_nettype none
module ext_pin_source (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [2:0]  pinSel,
	input  wire logic [15:0] width,
	input  wire logic        level,
	output var  logic [4:0]  pinLvl
);
	// Cycles left in the running pulse
	logic [15:0] left_r = 16'h0;
	// Pin that the running pulse belongs to
	logic [2:0]  held_r = 3'h0;

	// Idle levels: falling-edge pins high, three held high through reset
	initial pinLvl = 5'h15;

	// Width zero is a lasting step; otherwise a pulse of width cycles
	always @(posedge clk) begin
		if (go) begin
			held_r <= pinSel;
			left_r <= width;
			pinLvl[pinSel] <= (width == 16'h0) ? level : !pinLvl[pinSel];
		end else if (left_r == 16'h1) begin
			pinLvl[held_r] <= !pinLvl[held_r];
			left_r <= 16'h0;
		end else if (left_r != 16'h0) begin
			left_r <= left_r - 16'h1;
		end
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ext_irq_pkg::*;
	localparam int TIMEOUT_CYC = 40000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, reqValid, portInValue;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] reqSource;
	logic timerFourIrq = 1'b0, acceptStrobe = 1'b0;
	logic go = 1'b0, level = 1'b0;
	logic [2:0] pinSel = 3'h0;
	logic [15:0] width = 16'h0;
	wire logic [4:0] pinLvl;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h3fdb;
	// Expected answers, oldest first
	logic [31:0] expData[$];
	logic [1:0] expResp[$];
	logic [1:0] expB[$];

	always #50 clk = !clk;

	external_interrupt_inputs u_external_interrupt_inputs (.clk(clk),
		.rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sharedPortPin(pinLvl[0]),
		.extIrqOne(pinLvl[1]), .extIrqThree(pinLvl[2]),
		.extIrqFour(pinLvl[3]), .extIrqFive(pinLvl[4]),
		.timerFourIrq(timerFourIrq), .acceptStrobe(acceptStrobe),
		.reqValid(reqValid), .reqSource(reqSource),
		.portInValue(portInValue));
	ext_pin_source u_ext_pin_source (.clk(clk), .go(go), .pinSel(pinSel),
		.width(width), .level(level), .pinLvl(pinLvl));

	function logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp_word(input string what, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_resp(input string what, input logic [1:0] e,
		input logic [1:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] idx, input logic [31:0] d,
		input logic [1:0] er);
		logic aOk;
		logic wOk;
		aOk = 1'b0;
		wOk = 1'b0;
		expB.push_back(er);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aOk && wOk)) begin
			@(posedge clk);
			if (!aOk && awready) begin
				aOk = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wOk && wready) begin
				wOk = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Answer seen first, taken an edge later, so it must stand
		do @(posedge clk); while (!bvalid);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
		input logic [1:0] er);
		expData.push_back(ed);
		expResp.push_back(er);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	// Read the latches, then clear them all
	task automatic chk_latch(input logic [31:0] e);
		rd(LATCH_IDX, e, RESP_OKAY);
		wr(LATCH_IDX, 32'h1f, RESP_OKAY);
	endtask

	task automatic pin(input logic [2:0] s, input logic [15:0] w,
		input logic l, input int settle);
		pinSel <= s;
		width <= w;
		level <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (int'(w) + settle) @(posedge clk);
	endtask

	// Answers are checked against the oldest note as they are taken
	always @(posedge clk) begin
		if (rvalid && rready) begin
			cmp_word("rdata", expData.pop_front(), rdata);
			cmp_resp("rresp", expResp.pop_front(), rresp);
		end
		if (bvalid && bready) begin
			cmp_resp("bresp", expB.pop_front(), bresp);
		end
	end

	// A hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		rd(CTRL_IDX, 32'h0, RESP_OKAY);
		rd(MISC_IDX, 32'h0, RESP_OKAY);
		rd(8'(next_rand() % 32'h37), 32'h0, RESP_SLVERR);
		wr(8'h00, 32'hff, RESP_SLVERR);
		wr(CTRL_IDX, 32'hff, RESP_OKAY);
		rd(CTRL_IDX, 32'hfe, RESP_OKAY);
		// Level mode on three while its pin stayed high since reset
		wr(CTRL_IDX, 32'h30, RESP_OKAY);
		wr(MISC_IDX, 32'h2, RESP_OKAY);
		pin(3'h2, 16'h0, 1'b1, 30);
		chk_latch(32'h0);
		wr(CTRL_IDX, 32'h0, RESP_OKAY);
		pin(3'h0, 16'd10, 1'b0, 30);
		chk_latch(32'h0);
		wr(CTRL_IDX, 32'h40, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			pin(k ? 3'h4 : 3'h0, 16'd1, 1'b0, 30);
			chk_latch(32'h0);
			pin(k ? 3'h4 : 3'h0, 16'd7, 1'b0, 30);
			chk_latch(k ? 32'h10 : 32'h1);
		end
		wr(CTRL_IDX, 32'h2, RESP_OKAY);
		pin(3'h1, 16'h0, 1'b1, 80);
		chk_latch(32'h0);
		pin(3'h1, 16'h0, 1'b0, 80);
		chk_latch(32'h2);
		wr(CTRL_IDX, 32'h0, RESP_OKAY);
		pin(3'h1, 16'(next_rand() % 62 + 1), 1'b0, 80);
		chk_latch(32'h0);
		pin(3'h1, 16'd193, 1'b0, 80);
		chk_latch(32'h2);
		wr(CTRL_IDX, 32'h80, RESP_OKAY);
		pin(3'h1, 16'd49, 1'b0, 80);
		chk_latch(32'h2);
		pin(3'h1, 16'd14, 1'b0, 80);
		chk_latch(32'h0);
		pin(3'h2, 16'h0, 1'b0, 40);
		pin(3'h2, 16'(next_rand() % 6 + 1), 1'b1, 40);
		chk_latch(32'h0);
		// Every sensitivity code on three and four at once
		for (int s = 0; s < 4; s++) begin
			wr(CTRL_IDX, 32'((s << 4) | (s << 2)), RESP_OKAY);
			chk_latch(32'h0);
			pin(3'h2, 16'h0, 1'b1, 1);
			pin(3'h3, 16'h0, 1'b1, 40);
			chk_latch((s != 1) ? 32'hc : 32'h0);
			pin(3'h2, 16'h0, 1'b0, 1);
			pin(3'h3, 16'h0, 1'b0, 40);
			chk_latch((s != 0) ? 32'hc : 32'h0);
		end
		// Timer source on the shared slot, then acceptance
		wr(MISC_IDX, 32'h0, RESP_OKAY);
		timerFourIrq <= 1'b1;
		@(posedge clk);
		timerFourIrq <= 1'b0;
		wr(ENABLE_IDX, 32'h1f, RESP_OKAY);
		wr(MISC_IDX, 32'h1, RESP_OKAY);
		repeat (3) @(posedge clk);
		cmp_word("reqValid", 32'h1, 32'(reqValid));
		cmp_word("reqSource", 32'h2, 32'(reqSource));
		acceptStrobe <= 1'b1;
		@(posedge clk);
		acceptStrobe <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_word("reqValid", 32'h0, 32'(reqValid));
		rd(MISC_IDX, 32'h0, RESP_OKAY);
		chk_latch(32'h0);
		// Slow sampling: under one slow period vanishes
		// enables masked first
		wr(ENABLE_IDX, 32'h0, RESP_OKAY);
		wr(MISC_IDX, 32'h4, RESP_OKAY);
		pin(3'h4, 16'(next_rand() % 300 + 1), 1'b0, 700);
		chk_latch(32'h0);
		pin(3'h4, 16'd1069, 1'b0, 700);
		chk_latch(32'h10);
		end_of_test();
	end
endmodule
`default_nettype wire
